// >>> gpom_pkg.sv
// Constants and types for the pin 7 output multiplexer
package gpom_pkg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_PIN_CTL = 8'h17;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h40;
  localparam logic [7:0] PIN_CTL_RESET = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int SRC_MSB = 4;
  localparam int SRC_LSB = 2;
  localparam int VAL_BIT = 1;
  localparam int EN_BIT = 0;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_LEVEL_BIT = 1;
  localparam int STAT_RSVD_BIT = 2;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_RX = 4;
  localparam int NUM_TX = 2;
  localparam int PINS_PER_RX = 4;
  localparam int NUM_SEL = 8;
  localparam int RST_STAGES = 2;

  // ----------------------------------------------------------------------
  // Output source codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_RX0 = 3'b000,
    SRC_RX1 = 3'b001,
    SRC_RX2 = 3'b010,
    SRC_RX3 = 3'b011,
    SRC_DEV = 3'b100,
    SRC_RSVD = 3'b101,
    SRC_TX0 = 3'b110,
    SRC_TX1 = 3'b111
  } gpom_src_e;

  // ----------------------------------------------------------------------
  // Signal select codes, per source group
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_RX_PIN0 = 3'b000;
  localparam logic [2:0] SEL_RX_PIN1 = 3'b001;
  localparam logic [2:0] SEL_RX_PIN2 = 3'b010;
  localparam logic [2:0] SEL_RX_PIN3 = 3'b011;
  localparam logic [2:0] SEL_RX_LOCK = 3'b100;
  localparam logic [2:0] SEL_RX_PASS = 3'b101;
  localparam logic [2:0] SEL_RX_FV = 3'b110;
  localparam logic [2:0] SEL_RX_LV = 3'b111;

  localparam logic [2:0] SEL_DEV_REG = 3'b000;
  localparam logic [2:0] SEL_DEV_OR_LOCK = 3'b001;
  localparam logic [2:0] SEL_DEV_AND_LOCK = 3'b010;
  localparam logic [2:0] SEL_DEV_AND_PASS = 3'b011;
  localparam logic [2:0] SEL_DEV_FTRIG = 3'b100;
  localparam logic [2:0] SEL_DEV_LAST = 3'b100;

  localparam logic [2:0] SEL_TX_AND_PASS = 3'b000;
  localparam logic [2:0] SEL_TX_OR_PASS = 3'b001;
  localparam logic [2:0] SEL_TX_FV = 3'b010;
  localparam logic [2:0] SEL_TX_LV = 3'b011;
  localparam logic [2:0] SEL_TX_SYNC = 3'b100;
  localparam logic [2:0] SEL_TX_IRQ = 3'b101;
  localparam logic [2:0] SEL_TX_LAST = 3'b101;

endpackage : gpom_pkg

// >>> gpom_select.sv
// Final source and signal selection for the pin 7 output
module gpom_select
  import gpom_pkg::*;
(
  input wire logic [2:0] source_i,
  input wire logic [2:0] select_i,
  input wire logic [NUM_RX*NUM_SEL-1:0] rx_vec_i,
  input wire logic [NUM_SEL-1:0] dev_vec_i,
  input wire logic [NUM_TX*NUM_SEL-1:0] tx_vec_i,
  output logic level_o,
  output logic reserved_o
);

  always_comb begin
    level_o = 1'b0;
    reserved_o = 1'b0;
    case (gpom_src_e'(source_i))
      SRC_RX0, SRC_RX1, SRC_RX2, SRC_RX3: begin
        level_o = rx_vec_i[{source_i[1:0], select_i}];
      end
      SRC_DEV: begin
        if (select_i > SEL_DEV_LAST) begin
          reserved_o = 1'b1;
        end else begin
          level_o = dev_vec_i[select_i];
        end
      end
      SRC_TX0, SRC_TX1: begin
        if (select_i > SEL_TX_LAST) begin
          reserved_o = 1'b1;
        end else begin
          level_o = tx_vec_i[{source_i[0], select_i}];
        end
      end
      default: begin
        reserved_o = 1'b1;
      end
    endcase
  end

endmodule : gpom_select

// >>> gpom_top.sv
// Register-controlled output multiplexer for general-purpose pin 7

module gpom_top
  import gpom_pkg::*;
#(
  parameter int RX_PORTS = NUM_RX,
  parameter int TX_PORTS = NUM_TX
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Receive port status
  input wire logic [RX_PORTS*PINS_PER_RX-1:0] rx_remote_pin_i,
  input wire logic [RX_PORTS-1:0] rx_lock_i,
  input wire logic [RX_PORTS-1:0] rx_pass_i,
  input wire logic [RX_PORTS-1:0] rx_frame_valid_i,
  input wire logic [RX_PORTS-1:0] rx_line_valid_i,
  input wire logic [RX_PORTS-1:0] rx_port_enabled_i,
  // Device status
  input wire logic frame_trigger_i,
  // Transmit port status
  input wire logic [TX_PORTS*RX_PORTS-1:0] tx_rx_map_i,
  input wire logic [TX_PORTS-1:0] tx_frame_valid_i,
  input wire logic [TX_PORTS-1:0] tx_line_valid_i,
  input wire logic [TX_PORTS-1:0] tx_synced_i,
  input wire logic [TX_PORTS-1:0] tx_irq_i,
  // Pin drive
  output logic pin7_out_o,
  output logic pin7_oe_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [RST_STAGES-1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[RST_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[RST_STAGES-1];

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [2:0] pin7_signal_select;
  logic [2:0] pin7_source_select;
  logic pin7_register_level;
  logic pin7_drive_enable;
  logic ctl_wr;

  assign ctl_wr = reg_wr_i && (reg_addr_i == OFF_PIN_CTL);

  // One process per field; they share only the write decode
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_signal_select <= PIN_CTL_RESET[SEL_MSB:SEL_LSB];
    end else if (ctl_wr) begin
      pin7_signal_select <= reg_wdata_i[SEL_MSB:SEL_LSB];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_source_select <= PIN_CTL_RESET[SRC_MSB:SRC_LSB];
    end else if (ctl_wr) begin
      pin7_source_select <= reg_wdata_i[SRC_MSB:SRC_LSB];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_register_level <= PIN_CTL_RESET[VAL_BIT];
    end else if (ctl_wr) begin
      pin7_register_level <= reg_wdata_i[VAL_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_drive_enable <= PIN_CTL_RESET[EN_BIT];
    end else if (ctl_wr) begin
      pin7_drive_enable <= reg_wdata_i[EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Per receive port signal vectors, indexed by select code
  // ----------------------------------------------------------------------
  logic [NUM_RX*NUM_SEL-1:0] rx_vec;
  logic [NUM_RX-1:0] lock_q;
  logic [NUM_RX-1:0] pass_q;
  logic [NUM_RX-1:0] en_q;

  // Ports beyond RX_PORTS read as absent: not enabled, all low
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RX; gi++) begin : g_rx
      if (gi < RX_PORTS) begin : g_live
        logic [NUM_SEL-1:0] slot;
        // Slot index is the select code, so the mux needs no decode here
        assign slot[SEL_RX_PIN0] = rx_remote_pin_i[gi*PINS_PER_RX];
        assign slot[SEL_RX_PIN1] = rx_remote_pin_i[gi*PINS_PER_RX+1];
        assign slot[SEL_RX_PIN2] = rx_remote_pin_i[gi*PINS_PER_RX+2];
        assign slot[SEL_RX_PIN3] = rx_remote_pin_i[gi*PINS_PER_RX+3];
        assign slot[SEL_RX_LOCK] = rx_lock_i[gi];
        assign slot[SEL_RX_PASS] = rx_pass_i[gi];
        assign slot[SEL_RX_FV] = rx_frame_valid_i[gi];
        assign slot[SEL_RX_LV] = rx_line_valid_i[gi];
        assign rx_vec[gi*NUM_SEL +: NUM_SEL] = slot;
        assign lock_q[gi] = rx_lock_i[gi];
        assign pass_q[gi] = rx_pass_i[gi];
        assign en_q[gi] = rx_port_enabled_i[gi];
      end else begin : g_absent
        assign rx_vec[gi*NUM_SEL +: NUM_SEL] = '0;
        assign lock_q[gi] = 1'b0;
        assign pass_q[gi] = 1'b0;
        assign en_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Device status group
  // ----------------------------------------------------------------------
  // With no port enabled the AND terms read low, so an idle hub never
  // reports every link good.
  logic any_en;
  logic or_lock;
  logic and_lock;
  logic and_pass;
  logic [NUM_SEL-1:0] dev_vec;

  assign any_en = |en_q;
  assign or_lock = |(lock_q & en_q);
  assign and_lock = any_en && ((lock_q | ~en_q) == {NUM_RX{1'b1}});
  assign and_pass = any_en && ((pass_q | ~en_q) == {NUM_RX{1'b1}});

  assign dev_vec[SEL_DEV_REG] = pin7_register_level;
  assign dev_vec[SEL_DEV_OR_LOCK] = or_lock;
  assign dev_vec[SEL_DEV_AND_LOCK] = and_lock;
  assign dev_vec[SEL_DEV_AND_PASS] = and_pass;
  assign dev_vec[SEL_DEV_FTRIG] = frame_trigger_i;
  // Codes above the last live one are reserved and never reach the pin
  assign dev_vec[NUM_SEL-1:SEL_DEV_LAST+1] = '0;

  // ----------------------------------------------------------------------
  // Per transmit port signal vectors
  // ----------------------------------------------------------------------
  logic [NUM_TX*NUM_SEL-1:0] tx_vec;

  generate
    for (gi = 0; gi < NUM_TX; gi++) begin : g_tx
      if (gi < TX_PORTS) begin : g_live
        logic [NUM_RX-1:0] map;
        logic any_map;
        logic t_and;
        logic t_or;
        logic [NUM_SEL-1:0] slot;
        if (RX_PORTS < NUM_RX) begin : g_pad
          assign map = {{(NUM_RX-RX_PORTS){1'b0}},
                        tx_rx_map_i[gi*RX_PORTS +: RX_PORTS]};
        end else begin : g_full
          assign map = tx_rx_map_i[gi*RX_PORTS +: NUM_RX];
        end
        assign any_map = |map;
        assign t_and = any_map && ((pass_q | ~map) == {NUM_RX{1'b1}});
        assign t_or = |(pass_q & map);
        // With no receive port chosen both pass terms read low
        assign slot[SEL_TX_AND_PASS] = t_and;
        assign slot[SEL_TX_OR_PASS] = t_or;
        assign slot[SEL_TX_FV] = tx_frame_valid_i[gi];
        assign slot[SEL_TX_LV] = tx_line_valid_i[gi];
        assign slot[SEL_TX_SYNC] = tx_synced_i[gi];
        assign slot[SEL_TX_IRQ] = tx_irq_i[gi];
        assign slot[NUM_SEL-1:SEL_TX_LAST+1] = '0;
        assign tx_vec[gi*NUM_SEL +: NUM_SEL] = slot;
      end else begin : g_absent
        assign tx_vec[gi*NUM_SEL +: NUM_SEL] = '0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Source and signal selection
  // ----------------------------------------------------------------------
  logic sel_level;
  logic sel_reserved;

  gpom_select u_select (
    .source_i(pin7_source_select),
    .select_i(pin7_signal_select),
    .rx_vec_i(rx_vec),
    .dev_vec_i(dev_vec),
    .tx_vec_i(tx_vec),
    .level_o(sel_level),
    .reserved_o(sel_reserved)
  );

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Level is held low while disabled so the pad never sees a stale value
  // at the moment the enable rises; costs one cycle of latency.
  logic next_pin_out;

  always_comb begin
    next_pin_out = 1'b0;
    if (pin7_drive_enable && !sel_reserved) begin
      next_pin_out = sel_level;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_out_o <= 1'b0;
    end else begin
      pin7_out_o <= next_pin_out;
    end
  end

  // Enable copy lags the field by one cycle, in step with the level
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin7_oe_o <= 1'b0;
    end else begin
      pin7_oe_o <= pin7_drive_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] ctl_word;
  logic [DATA_W-1:0] status_word;

  always_comb begin
    ctl_word = RD_IDLE;
    ctl_word[SEL_MSB:SEL_LSB] = pin7_signal_select;
    ctl_word[SRC_MSB:SRC_LSB] = pin7_source_select;
    ctl_word[VAL_BIT] = pin7_register_level;
    ctl_word[EN_BIT] = pin7_drive_enable;
  end

  // Enable and level bits show the pin as driven, one cycle behind the control fields; the reserved bit follows them with no delay
  always_comb begin
    status_word = RD_IDLE;
    status_word[STAT_EN_BIT] = pin7_oe_o;
    status_word[STAT_LEVEL_BIT] = pin7_out_o;
    status_word[STAT_RSVD_BIT] = sel_reserved;
  end

  // ----------------------------------------------------------------------
  // Read strobe decode
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = RD_IDLE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_PIN_CTL: begin
          next_rdata = ctl_word;
        end
        OFF_PIN_STATUS: begin
          next_rdata = status_word;
        end
        default: begin
          next_rdata = RD_IDLE;
        end
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= RD_IDLE;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : gpom_top

// >>> gpom_assertions.sv
// Port-level checks for the pin 7 output multiplexer
module gpom_assertions
  import gpom_pkg::*;
#(
  parameter int RX_PORTS = NUM_RX,
  parameter int TX_PORTS = NUM_TX
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [RX_PORTS*PINS_PER_RX-1:0] rx_remote_pin_i,
  input wire logic [RX_PORTS-1:0] rx_lock_i,
  input wire logic [RX_PORTS-1:0] rx_port_enabled_i,
  input wire logic frame_trigger_i,
  input wire logic [TX_PORTS-1:0] tx_irq_i,
  input wire logic pin7_out_o,
  input wire logic pin7_oe_o
);
  // Shadow of the control register, then the copy the pin stage sees
  logic [7:0] ctl;
  logic [7:0] c;
  logic [15:0] rp;
  logic [3:0] lk;
  logic [3:0] en;
  logic ft;
  logic [1:0] irq;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl <= 8'h00;
      c <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == OFF_PIN_CTL) begin
        ctl <= reg_wdata_i;
      end
      c <= ctl;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    rp <= rx_remote_pin_i;
    lk <= rx_lock_i;
    en <= rx_port_enabled_i;
    ft <= frame_trigger_i;
    irq <= tx_irq_i;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  oe_copy_a: assert property (pin7_oe_o == c[EN_BIT])
    else $error("enable output differs from enable bit");
  off_low_a: assert property (!c[EN_BIT] |-> !pin7_out_o)
    else $error("pin high while disabled");
  rsvd_src_a: assert property (c[4:2] == 3'b101 |-> !pin7_out_o)
    else $error("reserved source drives high");
  rx_pin_a: assert property (c[0] && !c[4] && !c[7]
    |-> pin7_out_o == rp[{c[3:2], c[6:5]}]) else $error("rx pin wrong");
  rx_lock_a: assert property (c[0] && !c[4] && c[7:5] == 3'b100
    |-> pin7_out_o == lk[c[3:2]]) else $error("rx lock wrong");
  dev_reg_a: assert property (c[0] && c[7:2] == 6'b000100
    |-> pin7_out_o == c[VAL_BIT]) else $error("register level wrong");
  dev_or_a: assert property (c[0] && c[7:2] == 6'b001100
    |-> pin7_out_o == |(lk & en)) else $error("lock OR wrong");
  dev_trig_a: assert property (c[0] && c[7:2] == 6'b100100
    |-> pin7_out_o == ft) else $error("frame trigger wrong");
  tx_irq_a: assert property (c[0] && c[7:3] == 5'b10111
    |-> pin7_out_o == irq[c[2]]) else $error("tx interrupt wrong");
  tx_rsvd_a: assert property (c[4:3] == 2'b11 && c[7:6] == 2'b11
    |-> !pin7_out_o) else $error("reserved tx select high");
  cover property (c[0] && c[4:3] == 2'b11 && pin7_out_o);
  cover property (c[0] && c[7:2] == 6'b001100 && pin7_out_o);
  cover property (c[0] && !c[4] && pin7_out_o);
endmodule : gpom_assertions

bind gpom_top gpom_assertions #(.RX_PORTS(RX_PORTS), .TX_PORTS(TX_PORTS))
  gpom_assertions_inst (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .rx_remote_pin_i, .rx_lock_i, .rx_port_enabled_i,
  .frame_trigger_i, .tx_irq_i, .pin7_out_o, .pin7_oe_o);

// >>> gpom_pin_load.sv
// Far-side load on pin 7: the pad level the external device sees
module gpom_pin_load #(
  parameter logic PULL = 1'b0
) (
  input wire logic pin_out_i,
  input wire logic pin_oe_i,
  output logic pad_o
);
  // Released pad falls to the board pull, never keeps the last value
  assign pad_o = pin_oe_i ? pin_out_i : PULL;
endmodule : gpom_pin_load

// >>> gpio_pin7_output_mux_test.sv
// Self-checking bench for the pin 7 output multiplexer
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end \
end
module gpio_pin7_output_mux_test
  import gpom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // lv, fv, pass, lock, remote pins
  logic [31:0] rxv = 32'h0000_0000;
  logic [3:0] rx_en = 4'h0;
  logic ftr = 1'b0;
  // irq, sync, lv, fv, map
  logic [15:0] txv = 16'h0000;
  logic pin;
  logic oe;
  logic pad;
  logic [7:0] d;
  int n_errors = 0;
  int num_checks = 0;
  gpom_top gpom_top_inst (.clk_sys_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .rx_remote_pin_i(rxv[15:0]),
    .rx_lock_i(rxv[19:16]), .rx_pass_i(rxv[23:20]),
    .rx_frame_valid_i(rxv[27:24]), .rx_line_valid_i(rxv[31:28]),
    .rx_port_enabled_i(rx_en), .frame_trigger_i(ftr),
    .tx_rx_map_i(txv[7:0]), .tx_frame_valid_i(txv[9:8]),
    .tx_line_valid_i(txv[11:10]), .tx_synced_i(txv[13:12]),
    .tx_irq_i(txv[15:14]), .pin7_out_o(pin), .pin7_oe_o(oe));
  // Board pull-up, so a released pad is told apart from a driven low
  gpom_pin_load #(.PULL(1'b1)) gpom_pin_load_inst (.pin_out_i(pin),
    .pin_oe_i(oe), .pad_o(pad));
  initial forever #5 clk = ~clk;
  // ------------------------------------------------------------------
  // Reference and bus tasks
  // ------------------------------------------------------------------
  function automatic logic model(input logic [7:0] c);
    logic [3:0] lk;
    logic [3:0] ps;
    logic [3:0] m;
    lk = rxv[19:16];
    ps = rxv[23:20];
    m = txv[c[2]*4 +: 4];
    if (!c[0] || c[4:2] == 3'b101) return 1'b0;
    if (!c[4]) return c[7] ? rxv[{1'b1, c[6:5], c[3:2]}]
                           : rxv[{1'b0, c[3:2], c[6:5]}];
    if (!c[3]) begin
      case (c[7:5])
        3'd0: return c[1];
        3'd1: return |(lk & rx_en);
        3'd2: return |rx_en && &(lk | ~rx_en);
        3'd3: return |rx_en && &(ps | ~rx_en);
        3'd4: return ftr;
        default: return 1'b0;
      endcase
    end
    case (c[7:5])
      3'd0: return |m && &(ps | ~m);
      3'd1: return |(ps & m);
      3'd2, 3'd3, 3'd4, 3'd5: return txv[{1'b1, c[6:5] - 2'd2, c[2]}];
      default: return 1'b0;
    endcase
  endfunction : model
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Data stand only until the next edge, so take them 1 ns after this one
    #1 v = rdata;
  endtask : rd_reg
  // Pin follows a control write one edge after the write edge
  task automatic apply(input logic [7:0] c);
    wr_reg(OFF_PIN_CTL, c);
    repeat (2) @(posedge clk);
    #1;
  endtask : apply
  task automatic drive(input logic [31:0] r, input logic [3:0] e,
                       input logic f, input logic [15:0] t);
    @(posedge clk);
    rxv <= r;
    rx_en <= e;
    ftr <= f;
    txv <= t;
  endtask : drive
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd_reg(OFF_PIN_CTL, d);
    `CHK("control", PIN_CTL_RESET, d);
    `CHK("oe", 1'b0, oe);
    `CHK("pad", 1'b1, pad);
    rd_reg(8'h55, d);
    `CHK("unmapped", RD_IDLE, d);
  endtask : t_reset
  task automatic t_rx();
    for (int v = 0; v < 2; v++) begin
      drive(v ? 32'h5A3C_61E8 : 32'hA5C3_9E17, 4'hF, 1'b1, 16'hFFFF);
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < 8; s++) begin
          apply({3'(s), 1'b0, 2'(p), 2'b01});
          `CHK("rx pin", model({3'(s), 1'b0, 2'(p), 2'b01}), pin);
          `CHK("rx pad", model({3'(s), 1'b0, 2'(p), 2'b01}), pad);
        end
      end
    end
    `CHK("oe", 1'b1, oe);
  endtask : t_rx
  task automatic t_dev();
    logic [7:0] st[3] = '{8'h54, 8'hBA, 8'hFF};
    for (int k = 0; k < 3; k++) begin
      drive({8'h00, st[k], 16'h0000}, 4'h5, k != 0, 16'h0000);
      for (int s = 0; s < 8; s++) begin
        apply({3'(s), 3'b100, k != 1, 1'b1});
        `CHK("dev", model({3'(s), 3'b100, k != 1, 1'b1}), pin);
      end
    end
  endtask : t_dev
  task automatic t_tx();
    for (int k = 0; k < 2; k++) begin
      drive({8'h00, k ? 8'h20 : 8'h50, 16'hFFFF}, 4'hF, 1'b0,
            k ? 16'h63CA : 16'h9C35);
      for (int t = 0; t < 2; t++) begin
        for (int s = 0; s < 8; s++) begin
          apply({3'(s), 2'b11, 1'(t), 2'b01});
          `CHK("tx", model({3'(s), 2'b11, 1'(t), 2'b01}), pin);
        end
      end
    end
  endtask : t_tx
  task automatic t_off();
    drive(32'hFFFF_FFFF, 4'hF, 1'b1, 16'hFFFF);
    apply(8'h12);
    `CHK("off pin", 1'b0, pin);
    `CHK("off oe", 1'b0, oe);
    `CHK("off pad", 1'b1, pad);
    apply(8'h17);
    `CHK("rsvd src", 1'b0, pin);
    rd_reg(OFF_PIN_STATUS, d);
    `CHK("status", 8'h05, d);
    wr_reg(OFF_PIN_STATUS, 8'hFF);
    rd_reg(OFF_PIN_CTL, d);
    `CHK("readback", 8'h17, d);
  endtask : t_off
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    #100us;
    n_errors++;
    close_out();
  end
  initial begin
    do_reset();
    t_reset();
    t_rx();
    t_dev();
    t_tx();
    t_off();
    apply(8'h93);
    do_reset();
    t_reset();
    close_out();
  end
endmodule : gpio_pin7_output_mux_test
